/* design/capstan_defines.vh */
/*
  constants for the capstan motor handshake block: state codes, field
  positions and the timing counts of the tachometer interval counter.
  assumes a 50 MHz clock; included by bare name from the design files.
*/
`ifndef CAPSTAN_DEFINES_VH
`define CAPSTAN_DEFINES_VH

// ------------------------------------------------------------
// clock and timing
// ------------------------------------------------------------
`define CLK_MHZ            50
`define TACH_CYC_PER_REV   8
`define TACH_TIMEOUT_US    2000
`define TACH_TIMEOUT_CYC   (`TACH_TIMEOUT_US * `CLK_MHZ)
`define TACH_CNT_W         17
`define SPEED_SLOW_PERIOD  17'h061a8
`define SPEED_FAST_PERIOD  17'h030d4
`define SPEED_TOL          17'h00400
`define RAMP_US            7000
`define RAMP_CYC           (`RAMP_US * `CLK_MHZ)
`define RAMP_CNT_W         19

// ------------------------------------------------------------
// sequencer states
// ------------------------------------------------------------
`define ST_IDLE   3'h0
`define ST_RAMP   3'h1
`define ST_SPEED  3'h2
`define ST_BRAKE  3'h3
`define ST_STALL  3'h4
`define ST_ACK    3'h5

// ------------------------------------------------------------
// status field positions (stopped, at-speed)
// ------------------------------------------------------------
`define STAT_STOPPED_BIT  1
`define STAT_ATSPEED_BIT  0
`define STAT_RAMP_BRAKE   2'h0
`define STAT_AT_SPEED     2'h1
`define STAT_STOPPED      2'h2
`define STAT_STALLED      2'h3

`endif

/* design/tach_timer.v */
/*
  tachometer interval timer: counts clock cycles between rising tach
  edges, reports each measured period and an overflow level.
  assumes the tach input is already synchronised to clock.
*/
`timescale 1ns/100ps
`include "capstan_defines.vh"

module tach_timer #(
  parameter TIMEOUT_CYC = `TACH_TIMEOUT_CYC
) (
  input  wire                    clock,
  input  wire                    reset,
  input  wire                    tach_sync,
  output reg                     period_valid_ff,
  output reg  [`TACH_CNT_W-1:0]  period_ff,
  output reg                     overflow_ff
);

  // ------------------------------------------------------------
  // edge detect and interval count
  // ------------------------------------------------------------
  reg                    tach_last_ff;  // previous tach level
  reg [`TACH_CNT_W-1:0]  count_ff;      // cycles since last edge
  wire                   tach_rise;     // one tach cycle completed

  assign tach_rise = tach_sync & ~tach_last_ff;

  // one count per tach cycle; eight per revolution, so speed is per period
  always @(posedge clock) begin
    if (reset) begin
      tach_last_ff    <= 1'b0;
      count_ff        <= {`TACH_CNT_W{1'b0}};
      period_valid_ff <= 1'b0;
      period_ff       <= {`TACH_CNT_W{1'b0}};
      overflow_ff     <= 1'b1;
    end else begin
      tach_last_ff    <= tach_sync;
      period_valid_ff <= 1'b0;
      if (tach_rise) begin
        period_ff       <= count_ff;
        period_valid_ff <= ~overflow_ff;
        count_ff        <= {`TACH_CNT_W{1'b0}};
        overflow_ff     <= 1'b0;
      end else if (count_ff == TIMEOUT_CYC[`TACH_CNT_W-1:0]) begin
        overflow_ff <= 1'b1;
      end else begin
        count_ff <= count_ff + 1'b1;
      end
    end
  end

endmodule

/* design/capstan_motor_handshake.v */
/*
  capstan motor handshake: host sequencer of the motor driver. takes run,
  direction and speed requests, reports stopped/at-speed status, drives
  the six commutation switches from three hall sensors.
  assumes all motor and host inputs are asynchronous to clock.
*/
// Contract
// - status pair encodes ramp, speed, stopped, stalled
// - run request clears stopped, starts motor
// - at-speed only after commanded speed reached
// - run withdrawn clears at-speed, starts braking
// - stopped set once motor at rest
// - stall sets both flags until run withdrawn
// - host withdraws run; at-speed clears, stopped stays
// - tachometer gives eight cycles per revolution
// - three hall sensors time winding commutation
// - interval counter overflow flags stall, brake end
`timescale 1ns/100ps
`include "capstan_defines.vh"

module capstan_motor_handshake #(
  parameter TIMEOUT_CYC = `TACH_TIMEOUT_CYC,
  parameter RAMP_CYC    = `RAMP_CYC
) (
  input  wire        clock,
  input  wire        reset,
  input  wire        run_request,
  input  wire        backward_dir,
  input  wire        speed_select,
  input  wire        tach_in,
  input  wire [2:0]  hall_in,
  output reg         stopped_flag,
  output reg         at_speed_flag,
  output reg  [2:0]  upper_drive,
  output reg  [2:0]  lower_drive
);

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  reg  [6:0]  sync1_ff;  // first stage, read only by second stage
  reg  [6:0]  sync2_ff;  // second stage, safe to use
  wire        run_s;     // synced run request
  wire        dir_s;     // synced direction
  wire        spd_s;     // synced speed select
  wire        tach_s;    // synced tachometer
  wire [2:0]  hall_s;    // synced hall sensors

  // two flops on every pin input
  always @(posedge clock) begin
    if (reset) begin
      sync1_ff <= 7'h00;
      sync2_ff <= 7'h00;
    end else begin
      sync1_ff <= {hall_in, tach_in, speed_select, backward_dir, run_request};
      sync2_ff <= sync1_ff;
    end
  end

  assign run_s  = sync2_ff[0];
  assign dir_s  = sync2_ff[1];
  assign spd_s  = sync2_ff[2];
  assign tach_s = sync2_ff[3];
  assign hall_s = sync2_ff[6:4];

  // ------------------------------------------------------------
  // tachometer timer
  // ------------------------------------------------------------
  wire                   period_valid;  // one pulse per tach cycle, none for the first edge after overflow
  wire [`TACH_CNT_W-1:0] period;        // last measured interval
  wire                   tach_ovf;      // no tach edge for timeout

  tach_timer #(
    .TIMEOUT_CYC (TIMEOUT_CYC)
  ) u_tach (
    .clock           (clock),
    .reset           (reset),
    .tach_sync       (tach_s),
    .period_valid_ff (period_valid),
    .period_ff       (period),
    .overflow_ff     (tach_ovf)
  );

  // ------------------------------------------------------------
  // sequencer registers
  // ------------------------------------------------------------
  reg  [2:0]               state_ff;      // host sequencer state
  reg  [2:0]               nxt_state;
  reg                      dir_ff;        // latched direction
  reg                      spd_ff;        // latched speed
  reg  [`RAMP_CNT_W-1:0]   ramp_cnt_ff;   // ramp grace timer
  reg  [`RAMP_CNT_W-1:0]   nxt_ramp_cnt;
  wire [`TACH_CNT_W-1:0]   target;        // commanded period
  wire                     in_window;     // measured period near target
  wire                     start;         // run newly requested

  assign target    = spd_ff ? `SPEED_FAST_PERIOD : `SPEED_SLOW_PERIOD;
  assign in_window = (period <= target + `SPEED_TOL) && (period + `SPEED_TOL >= target);
  assign start     = run_s && (state_ff == `ST_IDLE || state_ff == `ST_BRAKE);

  // direction and speed caught only on a start
  always @(posedge clock) begin
    if (reset) begin
      dir_ff <= 1'b0;
      spd_ff <= 1'b0;
    end else if (start) begin
      dir_ff <= dir_s;
      spd_ff <= spd_s;
    end
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always @* begin
    nxt_state    = state_ff;
    nxt_ramp_cnt = ramp_cnt_ff;
    case (state_ff)
      `ST_IDLE: begin
        if (run_s) begin
          nxt_state    = `ST_RAMP;
          nxt_ramp_cnt = {`RAMP_CNT_W{1'b0}};
        end
      end
      `ST_RAMP: begin
        if (!run_s) begin
          nxt_state = `ST_BRAKE;
        end else if (period_valid && in_window) begin
          nxt_state = `ST_SPEED;
        end else if (tach_ovf && ramp_cnt_ff == RAMP_CYC[`RAMP_CNT_W-1:0]) begin
          nxt_state = `ST_STALL;
        end else if (ramp_cnt_ff != RAMP_CYC[`RAMP_CNT_W-1:0]) begin
          nxt_ramp_cnt = ramp_cnt_ff + 1'b1;  // grace while spinning up
        end
      end
      `ST_SPEED: begin
        if (!run_s) begin
          nxt_state = `ST_BRAKE;
        end else if (tach_ovf) begin
          nxt_state = `ST_STALL;
        end
      end
      `ST_BRAKE: begin
        if (run_s) begin
          nxt_state    = `ST_RAMP;  // restart while braking
          nxt_ramp_cnt = {`RAMP_CNT_W{1'b0}};
        end else if (tach_ovf) begin
          nxt_state = `ST_IDLE;
        end
      end
      `ST_STALL: begin
        if (!run_s) begin
          nxt_state = `ST_ACK;
        end
      end
      `ST_ACK: begin
        nxt_state = `ST_IDLE;
      end
      default: begin
        nxt_state = `ST_IDLE;
      end
    endcase
  end

  // state register
  always @(posedge clock) begin
    if (reset) begin
      state_ff    <= `ST_IDLE;
      ramp_cnt_ff <= {`RAMP_CNT_W{1'b0}};
    end else begin
      state_ff    <= nxt_state;
      ramp_cnt_ff <= nxt_ramp_cnt;
    end
  end

  // ------------------------------------------------------------
  // status outputs
  // ------------------------------------------------------------
  reg [1:0] nxt_status;  // {stopped, at_speed}

  // status follows the next state so flags change with the state
  always @* begin
    case (nxt_state)
      `ST_IDLE:  nxt_status = `STAT_STOPPED;
      `ST_RAMP:  nxt_status = `STAT_RAMP_BRAKE;
      `ST_SPEED: nxt_status = `STAT_AT_SPEED;
      `ST_BRAKE: nxt_status = `STAT_RAMP_BRAKE;
      `ST_STALL: nxt_status = `STAT_STALLED;
      `ST_ACK:   nxt_status = `STAT_STOPPED;
      default:   nxt_status = `STAT_STOPPED;
    endcase
  end

  always @(posedge clock) begin
    if (reset) begin
      stopped_flag  <= 1'b1;
      at_speed_flag <= 1'b0;
    end else begin
      stopped_flag  <= nxt_status[`STAT_STOPPED_BIT];
      at_speed_flag <= nxt_status[`STAT_ATSPEED_BIT];
    end
  end

  // ------------------------------------------------------------
  // commutation
  // ------------------------------------------------------------
  reg [2:0] nxt_upper;  // high-side switches
  reg [2:0] nxt_lower;  // low-side switches
  reg [2:0] hall_eff;   // hall code, inverted for reverse

  // six-step table; reverse inverts the hall code
  always @* begin
    hall_eff  = dir_ff ? ~hall_s : hall_s;
    nxt_upper = 3'h0;
    nxt_lower = 3'h0;
    if (state_ff == `ST_BRAKE) begin
      nxt_upper = 3'h7;  // all upper on shorts windings
    end else if (state_ff == `ST_RAMP || state_ff == `ST_SPEED) begin
      case (hall_eff)
        3'h1: begin nxt_upper = 3'h1; nxt_lower = 3'h2; end
        3'h3: begin nxt_upper = 3'h1; nxt_lower = 3'h4; end
        3'h2: begin nxt_upper = 3'h2; nxt_lower = 3'h4; end
        3'h6: begin nxt_upper = 3'h2; nxt_lower = 3'h1; end
        3'h4: begin nxt_upper = 3'h4; nxt_lower = 3'h1; end
        3'h5: begin nxt_upper = 3'h4; nxt_lower = 3'h2; end
        default: begin nxt_upper = 3'h0; nxt_lower = 3'h0; end
      endcase
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      upper_drive <= 3'h0;
      lower_drive <= 3'h0;
    end else begin
      upper_drive <= nxt_upper;
      lower_drive <= nxt_lower;
    end
  end

endmodule

/* testbench/capstan_chk.sv */
/* checker for the capstan handshake status pair and switch drives.
   assumes a bind onto the top module and a single clock domain. */
`timescale 1ns/100ps
module capstan_chk #(
  parameter TIMEOUT_CYC = 200,
  parameter RAMP_CYC    = 400
) (
  input wire       clock,
  input wire       reset,
  input wire       run_request,
  input wire       backward_dir,
  input wire       speed_select,
  input wire       tach_in,
  input wire [2:0] hall_in,
  input wire       stopped_flag,
  input wire       at_speed_flag,
  input wire [2:0] upper_drive,
  input wire [2:0] lower_drive
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  reg [19:0] quiet_ff;  // cycles with tach and run unchanged
  reg        tach_d_ff; // tach one cycle back
  reg        run_d_ff;  // run one cycle back
  // ------------------------------------------------
  // quiet timer: restarts on any tach or run movement
  // ------------------------------------------------
  always @(posedge clock) begin
    tach_d_ff <= tach_in;
    run_d_ff  <= run_request;
    if (reset || tach_in != tach_d_ff || run_request != run_d_ff)
      quiet_ff <= 20'h0;
    else if (quiet_ff != 20'hfffff)
      quiet_ff <= quiet_ff + 20'h1;
  end
  a_run_clears_stop: assert property (
    $rose(run_request) && stopped_flag && !at_speed_flag |-> ##[1:4] !stopped_flag)
    else $error("stopped flag held after run");
  a_speed_after_ramp: assert property (
    $rose(at_speed_flag) && !stopped_flag |-> $past(!stopped_flag && !at_speed_flag))
    else $error("at speed without ramp");
  a_drop_clears_speed: assert property (
    $fell(run_request) && at_speed_flag && !stopped_flag |-> ##[1:4] !at_speed_flag)
    else $error("at speed held after drop");
  a_no_run_speed: assert property (
    !run_request [*5] |-> !at_speed_flag || stopped_flag)
    else $error("at speed with run low");
  a_stop_after_brake: assert property (
    $rose(stopped_flag) && !at_speed_flag |-> $past(!at_speed_flag))
    else $error("stopped straight from speed");
  a_stall_holds: assert property (
    stopped_flag && at_speed_flag && run_request && $past(run_request) |=> stopped_flag && at_speed_flag)
    else $error("stall left with run high");
  a_ack_keeps_stop: assert property (
    $fell(at_speed_flag) && $past(stopped_flag) |-> stopped_flag)
    else $error("stopped lost on stall ack");
  a_no_shoot: assert property (
    (upper_drive & lower_drive) == 3'h0)
    else $error("both switches of a phase on");
  a_brake_drive: assert property (
    $fell(at_speed_flag) && !stopped_flag |=> upper_drive == 3'h7 && lower_drive == 3'h0)
    else $error("brake drive pattern wrong");
  a_quiet_stops: assert property (
    quiet_ff == TIMEOUT_CYC + 16 && !run_request |-> stopped_flag)
    else $error("no stop after tach went quiet");
  c_at_speed: cover property ($rose(at_speed_flag) && !stopped_flag);
  c_stall: cover property (stopped_flag && at_speed_flag);
  c_stall_ack: cover property ($fell(at_speed_flag) && stopped_flag);
endmodule

/* testbench/motor_model.sv */
/* behavioural capstan motor: tach square wave and hall codes.
   assumes the bench commands spin; a stalled shaft stands still. */
`timescale 1ns/100ps
module motor_model (
  input  wire        clock,
  input  wire        spin,
  input  wire        reverse,
  input  wire [15:0] half_cyc,
  output reg         tach_in,
  output wire [2:0]  hall_in
);
  reg  [15:0] cnt_ff;  // cycles into the tach half period
  reg  [2:0]  step_ff; // electrical step 0..5
  wire [17:0] codes = {3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1}; // hall code per step
  assign hall_in = codes[step_ff * 3 +: 3];
  initial begin
    tach_in = 1'b0;
    step_ff = 3'h0;
    cnt_ff  = 16'h0;
  end
  // shaft turns only while commanded; tach stands when at rest
  always @(posedge clock) begin
    if (!spin)
      cnt_ff <= half_cyc - 16'h0014;
    else if (cnt_ff >= half_cyc - 16'h0001) begin
      cnt_ff  <= 16'h0;
      tach_in <= !tach_in;
      if (!tach_in)
        step_ff <= reverse ? (step_ff == 3'h0 ? 3'h5 : step_ff - 3'h1) : (step_ff == 3'h5 ? 3'h0 : step_ff + 3'h1);
    end else
      cnt_ff <= cnt_ff + 16'h0001;
  end
endmodule

/* testbench/tb_capstan_motor_handshake.sv */
/* self-checking bench for the capstan handshake: run/stop rows,
   stall and ack, reset in mid-run. assumes the motor_model partner. */
`timescale 1ns/100ps
module tb_capstan_motor_handshake;
  localparam TO = 14000; // shortened tach overflow count
  localparam RP = 4000;  // shortened ramp time
  reg        clock, reset, run_request, backward_dir, speed_select, spin;
  reg [15:0] half_cyc;   // model tach half period
  reg [35:0] rows [0:1]; // speed, dir, half period, wait, status
  wire       tach_in, stopped_flag, at_speed_flag;
  wire [2:0] hall_in, upper_drive, lower_drive;
  integer    num_errors, n_tests, r;
  motor_model motor (.clock(clock), .spin(spin), .reverse(backward_dir), .half_cyc(half_cyc),
    .tach_in(tach_in), .hall_in(hall_in));
  capstan_motor_handshake #(.TIMEOUT_CYC(TO), .RAMP_CYC(RP)) dut (.clock(clock), .reset(reset),
    .run_request(run_request), .backward_dir(backward_dir), .speed_select(speed_select),
    .tach_in(tach_in), .hall_in(hall_in), .stopped_flag(stopped_flag), .at_speed_flag(at_speed_flag),
    .upper_drive(upper_drive), .lower_drive(lower_drive));
  always #10 clock = ~clock;
  // compare and count
  task check(input [2:0] seen, input [2:0] want);
    begin
      n_tests = n_tests + 1;
      if (seen !== want) begin
        num_errors = num_errors + 1;
        $display("Error %0t: saw %h want %h", $time, seen, want);
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  // bounded wait for a status pair, then compare it
  task wait_stat(input [1:0] want, input integer bound);
    integer i;
    begin
      i = 0;
      while ({stopped_flag, at_speed_flag} !== want && i < bound) begin
        @(posedge clock);
        #1 i = i + 1;
      end
      check({1'b0, stopped_flag, at_speed_flag}, {1'b0, want});
      if (i >= bound)
        tally_and_finish;
    end
  endtask
  initial begin
    clock = 1'b0; reset = 1'b1; run_request = 1'b0; backward_dir = 1'b0;
    speed_select = 1'b0; spin = 1'b0; half_cyc = 16'h0000; num_errors = 0; n_tests = 0;
    rows[0] = {1'b1, 1'b0, 16'h186a, 16'h9470, 2'h1}; // fast at target period
    rows[1] = {1'b0, 1'b1, 16'h05dc, 16'h2ee0, 2'h0}; // reverse slow, far off target
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    #1 check({1'b0, stopped_flag, at_speed_flag}, 3'h2);
    check(upper_drive | lower_drive, 3'h0);
    for (r = 0; r < 2; r = r + 1) begin
      @(posedge clock);
      {speed_select, backward_dir, half_cyc} <= rows[r][35:18];
      run_request <= 1'b1;
      spin <= 1'b1;
      wait_stat(2'h0, 8);
      repeat (rows[r][17:2]) @(posedge clock);
      #1 check({1'b0, stopped_flag, at_speed_flag}, {1'b0, rows[r][1:0]});
      check({2'b00, |lower_drive}, 3'h1);
      @(posedge clock);
      run_request <= 1'b0;
      repeat (5) @(posedge clock);
      #1 check({1'b0, stopped_flag, at_speed_flag}, 3'h0);
      check(upper_drive, 3'h7);
      check(lower_drive, 3'h0);
      @(posedge clock);
      spin <= 1'b0;
      wait_stat(2'h2, TO + 500);
      repeat (30) @(posedge clock);
    end
    @(posedge clock);
    run_request <= 1'b1;
    wait_stat(2'h3, TO + RP + 100);
    repeat (50) @(posedge clock);
    #1 check({1'b0, stopped_flag, at_speed_flag}, 3'h3);
    @(posedge clock);
    run_request <= 1'b0;
    wait_stat(2'h2, 8);
    @(posedge clock);
    run_request <= 1'b1;
    spin <= 1'b1;
    repeat (10) @(posedge clock);
    reset <= 1'b1;
    run_request <= 1'b0;
    spin <= 1'b0;
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    #1 check({1'b0, stopped_flag, at_speed_flag}, 3'h2);
    check(upper_drive | lower_drive, 3'h0);
    tally_and_finish;
  end
endmodule
bind capstan_motor_handshake capstan_chk #(.TIMEOUT_CYC(TIMEOUT_CYC), .RAMP_CYC(RAMP_CYC)) chk (
  .clock(clock), .reset(reset), .run_request(run_request), .backward_dir(backward_dir),
  .speed_select(speed_select), .tach_in(tach_in), .hall_in(hall_in), .stopped_flag(stopped_flag),
  .at_speed_flag(at_speed_flag), .upper_drive(upper_drive), .lower_drive(lower_drive));
